// [hw/eksf_pkg.sv]
// eksf_pkg: shared constants and types of the key and signature formatter.
// assumes byte-wide streams on one clock; all counts are in bytes.
package eksf_pkg;

    // ------------------------------------------------------------
    // operation codes on cmd_op
    // ------------------------------------------------------------
    localparam logic [3:0] OP_PRIV_WRITE = 4'h0;
    localparam logic [3:0] OP_PUB_WRITE = 4'h1;
    localparam logic [3:0] OP_PUB_READ = 4'h2;
    localparam logic [3:0] OP_KEY_GENERATE_CMD_MSG = 4'h3;
    localparam logic [3:0] OP_VERIFY_MSG = 4'h4;
    localparam logic [3:0] OP_SIG_PASS = 4'h5;
    localparam logic [3:0] OP_VALIDATE = 4'h6;
    localparam logic [3:0] OP_INVALIDATE = 4'h7;
    localparam logic [3:0] OP_CERT_CHECK = 4'h8;

    // ------------------------------------------------------------
    // object layouts, in bytes
    // ------------------------------------------------------------
    localparam logic [6:0] PRIV_LEN = 7'h24;
    localparam logic [6:0] KEY_PAD_LEN = 7'h04;
    localparam logic [6:0] COORD_LEN = 7'h20;
    localparam logic [6:0] Y_PAD_OFS = 7'h24;
    localparam logic [6:0] PUB_CMD_LEN = 7'h40;
    localparam logic [6:0] PUB_STORED_LEN = 7'h48;
    localparam logic [6:0] SIG_LEN = 7'h40;
    localparam logic [6:0] KEY_GENERATE_CMD_PAD_LEN = 7'h19;
    localparam logic [6:0] KEY_GENERATE_CMD_MSG_LEN = 7'h59;

    // ------------------------------------------------------------
    // validation nibble codes and pad byte value
    // ------------------------------------------------------------
    localparam logic [3:0] NIB_VALID = 4'h5;
    localparam logic [3:0] NIB_INVALID = 4'hA;
    localparam logic [7:0] PAD_BYTE = 8'h00;

    // ------------------------------------------------------------
    // slot and certificate limits
    // ------------------------------------------------------------
    localparam logic [15:0] SLOT_PUB_MIN = 16'h0008;
    localparam logic [15:0] SLOT_PUB_MAX = 16'h000F;
    localparam logic [15:0] CERT_SLOT_BYTES = 16'h01A0;
    localparam logic [15:0] DEV_CERT_BYTES = 16'h0048;
    localparam logic [15:0] SIGNER_CERT_BYTES = 16'h0088;

    // ------------------------------------------------------------
    // control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PARAM,
        ST_RUN
    } eksf_state_e;

endpackage

// [hw/eksf_layout.sv]
// eksf_layout: maps a command-format public key byte index (0..63)
// onto its place in the 72-byte stored layout.
// assumes the caller only presents indices below 64.
`timescale 1ns/100ps
module eksf_layout (
    // command-format index
    input wire logic [5:0] cmd_idx,
    // stored-format index
    output logic [6:0] stored_idx
);
    // x sits behind the first pad group, y behind the second
    // msb byte lowest
    always_comb begin
        if (cmd_idx[5]) begin
            stored_idx = {1'b0, cmd_idx} + eksf_pkg::KEY_PAD_LEN
                + eksf_pkg::KEY_PAD_LEN;
        end else begin
            stored_idx = {1'b0, cmd_idx} + eksf_pkg::KEY_PAD_LEN;
        end
    end
endmodule

// [hw/eksf_param_word.sv]
// eksf_param_word: joins two parameter bytes, low byte first, into a word.
// assumes bytes arrive from logic on the same clock.
`timescale 1ns/100ps
module eksf_param_word (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // byte side
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    // word side
    output logic [15:0] word,
    output logic word_valid
);
    typedef struct packed {
        logic [7:0] lo;
        logic have_lo;
        logic [15:0] word;
        logic valid;
    } eksf_pw_s;

    eksf_pw_s r;
    eksf_pw_s n;

    always_comb begin
        n = r;
        n.valid = 1'b0;
        if (clear) begin
            n.have_lo = 1'b0;
        end else if (byte_valid) begin
            if (!r.have_lo) begin
                n.lo = byte_data;
                n.have_lo = 1'b1;
            end else begin
                n.word = {byte_data, r.lo};
                n.valid = 1'b1;
                n.have_lo = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign word = r.word;
    assign word_valid = r.valid;
endmodule

// [hw/eksf_formatter.sv]
// eksf_formatter: packs and unpacks key, signature and hash-message bytes
// and keeps one stored public key image with its validation nibble.
// assumes command transport has already framed each operation: cmd_start
// with cmd_op, then two parameter bytes, then the payload, on one clock.
`timescale 1ns/100ps
module eksf_formatter (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command
    input wire logic cmd_start,
    input wire logic [3:0] cmd_op,
    input wire logic verify_pass,
    // input byte stream
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // output byte stream
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic out_ready,
    // status
    output logic busy,
    output logic done,
    output logic error,
    output logic key_usable,
    output logic [3:0] valid_nibble,
    output logic cert_two_fit
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        eksf_pkg::eksf_state_e state;
        logic [3:0] op;
        logic [6:0] cnt;
        logic [15:0] param;
        logic [71:0][7:0] obj;
        logic stored;
        logic [3:0] slot;
        logic in_ready;
        logic out_valid;
        logic [7:0] out_data;
        logic out_last;
        logic busy;
        logic done;
        logic error;
        logic key_usable;
        logic cert_two_fit;
    } eksf_core_s;

    eksf_core_s r;
    eksf_core_s n;

    logic take;
    logic out_free;
    logic fin;
    logic fin_err;
    logic [15:0] p_word;
    logic p_valid;
    logic [6:0] lay_idx;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // operations that name a public key slot
    function automatic logic pub_op(input logic [3:0] op);
        pub_op = (op == eksf_pkg::OP_PUB_WRITE) ||
                 (op == eksf_pkg::OP_PUB_READ) ||
                 (op == eksf_pkg::OP_VERIFY_MSG) ||
                 (op == eksf_pkg::OP_VALIDATE) ||
                 (op == eksf_pkg::OP_INVALIDATE);
    endfunction

    // operations that stream payload through to the output
    function automatic logic pass_op(input logic [3:0] op);
        pass_op = (op == eksf_pkg::OP_SIG_PASS) ||
                  (op == eksf_pkg::OP_KEY_GENERATE_CMD_MSG);
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    eksf_param_word u_param (
        .clock(clock),
        .rst_n(rst_n),
        .clear(r.state == eksf_pkg::ST_IDLE),
        .byte_valid(take && (r.state == eksf_pkg::ST_PARAM)),
        .byte_data(in_data),
        .word(p_word),
        .word_valid(p_valid)
    );

    eksf_layout u_layout (
        .cmd_idx(r.cnt[5:0]),
        .stored_idx(lay_idx)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.done = 1'b0;
        fin = 1'b0;
        fin_err = 1'b0;
        take = in_valid && r.in_ready;
        out_free = !r.out_valid || out_ready;
        if (r.out_valid && out_ready) begin
            n.out_valid = 1'b0;
            n.out_last = 1'b0;
        end
        case (r.state)
            eksf_pkg::ST_IDLE: begin
                if (cmd_start) begin
                    n.state = eksf_pkg::ST_PARAM;
                    n.op = cmd_op;
                    n.cnt = 7'h00;
                    n.busy = 1'b1;
                    n.error = 1'b0;
                    n.in_ready = 1'b1;
                end
            end
            eksf_pkg::ST_PARAM: begin
                if (take) begin
                    n.cnt = r.cnt + 7'h01;
                    if (r.cnt == 7'h01) begin
                        n.in_ready = 1'b0;
                    end
                end
                if (p_valid) begin
                    n.param = p_word;
                    n.cnt = 7'h00;
                    if (pub_op(r.op) && ((p_word < eksf_pkg::SLOT_PUB_MIN)
                        || (p_word > eksf_pkg::SLOT_PUB_MAX))) begin
                        fin = 1'b1;
                        fin_err = 1'b1;
                    end else if (pub_op(r.op)
                        && (r.op != eksf_pkg::OP_PUB_WRITE)
                        && !(r.stored && (r.slot == p_word[3:0]))) begin
                        // nothing stored for that slot
                        fin = 1'b1;
                        fin_err = 1'b1;
                    end else begin
                        case (r.op)
                            eksf_pkg::OP_CERT_CHECK: begin
                                n.cert_two_fit = {p_word, 1'b0} <=
                                    {1'b0, eksf_pkg::CERT_SLOT_BYTES};
                                fin = 1'b1;
                                fin_err = p_word > eksf_pkg::CERT_SLOT_BYTES;
                            end
                            eksf_pkg::OP_VALIDATE: begin
                                // valid only after a passing verify
                                if (verify_pass) begin
                                    n.obj[0][7:4] = eksf_pkg::NIB_VALID;
                                end
                                fin = 1'b1;
                                fin_err = !verify_pass;
                            end
                            eksf_pkg::OP_INVALIDATE: begin
                                n.obj[0][7:4] = eksf_pkg::NIB_INVALID;
                                fin = 1'b1;
                            end
                            eksf_pkg::OP_PUB_WRITE: begin
                                for (int i = 0; i < 4; i++) begin
                                    n.obj[i] = eksf_pkg::PAD_BYTE;
                                    n.obj[i + 36] = eksf_pkg::PAD_BYTE;
                                end
                                n.obj[0][7:4] = eksf_pkg::NIB_INVALID;
                                n.stored = 1'b0;
                                n.state = eksf_pkg::ST_RUN;
                                n.in_ready = 1'b1;
                            end
                            eksf_pkg::OP_PRIV_WRITE: begin
                                n.stored = 1'b0;
                                n.state = eksf_pkg::ST_RUN;
                                n.in_ready = 1'b1;
                            end
                            eksf_pkg::OP_SIG_PASS: begin
                                n.state = eksf_pkg::ST_RUN;
                                n.in_ready = 1'b1;
                            end
                            eksf_pkg::OP_KEY_GENERATE_CMD_MSG,
                            eksf_pkg::OP_PUB_READ,
                            eksf_pkg::OP_VERIFY_MSG: begin
                                n.state = eksf_pkg::ST_RUN;
                            end
                            default: begin
                                fin = 1'b1;
                                fin_err = 1'b1;
                            end
                        endcase
                    end
                end
            end
            eksf_pkg::ST_RUN: begin
                case (r.op)
                    eksf_pkg::OP_PRIV_WRITE: begin
                        // 36 bytes kept in arrival order
                        if (take) begin
                            n.obj[r.cnt] = in_data;
                            n.cnt = r.cnt + 7'h01;
                            fin = r.cnt == (eksf_pkg::PRIV_LEN - 7'h01);
                        end
                    end
                    eksf_pkg::OP_PUB_WRITE: begin
                        // 64 bytes spread over the stored image
                        if (take) begin
                            n.obj[lay_idx] = in_data;
                            n.cnt = r.cnt + 7'h01;
                            if (r.cnt == (eksf_pkg::PUB_CMD_LEN - 7'h01)) begin
                                fin = 1'b1;
                                n.stored = 1'b1;
                                n.slot = r.param[3:0];
                            end
                        end
                    end
                    eksf_pkg::OP_SIG_PASS: begin
                        if (take) begin
                            n.out_valid = 1'b1;
                            n.out_data = in_data;
                            n.out_last = r.cnt == (eksf_pkg::SIG_LEN - 7'h01);
                            n.cnt = r.cnt + 7'h01;
                            fin = n.out_last;
                        end
                    end
                    eksf_pkg::OP_KEY_GENERATE_CMD_MSG: begin
                        // zero pad run, then x and y from the link
                        if (r.cnt < eksf_pkg::KEY_GENERATE_CMD_PAD_LEN) begin
                            if (out_free) begin
                                n.out_valid = 1'b1;
                                n.out_data = eksf_pkg::PAD_BYTE;
                                n.out_last = 1'b0;
                                n.cnt = r.cnt + 7'h01;
                            end
                        end else if (take) begin
                            n.out_valid = 1'b1;
                            n.out_data = in_data;
                            n.out_last = r.cnt ==
                                (eksf_pkg::KEY_GENERATE_CMD_MSG_LEN - 7'h01);
                            n.cnt = r.cnt + 7'h01;
                            fin = n.out_last;
                        end
                    end
                    eksf_pkg::OP_PUB_READ: begin
                        if (out_free) begin
                            n.out_valid = 1'b1;
                            n.out_data = r.obj[lay_idx];
                            n.out_last = r.cnt ==
                                (eksf_pkg::PUB_CMD_LEN - 7'h01);
                            n.cnt = r.cnt + 7'h01;
                            fin = n.out_last;
                        end
                    end
                    eksf_pkg::OP_VERIFY_MSG: begin
                        // stored image as is, pads and nibble too
                        if (out_free) begin
                            n.out_valid = 1'b1;
                            n.out_data = r.obj[r.cnt];
                            n.out_last = r.cnt ==
                                (eksf_pkg::PUB_STORED_LEN - 7'h01);
                            n.cnt = r.cnt + 7'h01;
                            fin = n.out_last;
                        end
                    end
                    default: begin
                        fin = 1'b1;
                        fin_err = 1'b1;
                    end
                endcase
                // one byte in flight: take again only once output drained
                if (pass_op(r.op)) begin
                    n.in_ready = !n.out_valid && (n.cnt >=
                        ((r.op == eksf_pkg::OP_KEY_GENERATE_CMD_MSG) ?
                        eksf_pkg::KEY_GENERATE_CMD_PAD_LEN : 7'h00));
                end
            end
            default: begin
                n.state = eksf_pkg::ST_IDLE;
            end
        endcase
        if (fin) begin
            n.state = eksf_pkg::ST_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
            n.in_ready = 1'b0;
            n.error = fin_err;
        end
        n.key_usable = n.stored && (n.obj[0][7:4] == eksf_pkg::NIB_VALID);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign in_ready = r.in_ready;
    assign out_valid = r.out_valid;
    assign out_data = r.out_data;
    assign out_last = r.out_last;
    assign busy = r.busy;
    assign done = r.done;
    assign error = r.error;
    assign key_usable = r.key_usable;
    assign valid_nibble = r.obj[0][7:4];
    assign cert_two_fit = r.cert_two_fit;
endmodule

// [sim/eksf_formatter_props.sv]
// eksf_formatter_props: checks on the formatter's ports.
// assumes binding into eksf_formatter; streams drain before the next op.
`timescale 1ns/100ps
module eksf_formatter_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command and streams
    input wire logic cmd_start,
    input wire logic [3:0] cmd_op,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic out_ready,
    // status
    input wire logic busy,
    input wire logic done,
    input wire logic key_usable,
    input wire logic [3:0] valid_nibble
);
    logic [3:0] op_r;
    logic [6:0] cnt_r;
    logic go;
    logic vm;
    assign go = cmd_start && !busy;
    assign vm = op_r == eksf_pkg::OP_VERIFY_MSG && out_valid;
    // ----
    // op of the running stream, bytes accepted so far
    // ----
    always_ff @(posedge clock) begin
        if (!rst_n || go) begin
            op_r <= rst_n ? cmd_op : 4'hF;
            cnt_r <= 7'h00;
        end else if (out_valid && out_ready) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    out_hold_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)
        && $stable(out_last)) else $error("stalled byte changed");
    start_take_a: assert property (
        go |=> busy && in_ready) else $error("start not taken");
    done_pulse_a: assert property (
        done |=> !done) else $error("done longer than one cycle");
    nib_code_a: assert property (
        valid_nibble inside {4'h0, 4'h5, 4'hA}) else $error("bad nibble");
    usable_nib_a: assert property (
        key_usable |-> valid_nibble == eksf_pkg::NIB_VALID)
        else $error("usable key without valid nibble");
    gen_pad_a: assert property (
        op_r == eksf_pkg::OP_KEY_GENERATE_CMD_MSG && out_valid && cnt_r < 7'h19
        |-> out_data == 8'h00) else $error("hash pad not zero");
    gen_len_a: assert property (
        op_r == eksf_pkg::OP_KEY_GENERATE_CMD_MSG && out_valid && out_last
        |-> cnt_r == 7'h58) else $error("hash message length");
    verify_len_a: assert property (
        vm && out_last |-> cnt_r == 7'h47) else $error("digest length");
    verify_nib_a: assert property (
        vm && cnt_r == 7'h00 |-> out_data == {valid_nibble, 4'h0})
        else $error("first stored byte");
    verify_pad_a: assert property (
        vm && cnt_r inside {[7'h01:7'h03], [7'h24:7'h27]}
        |-> out_data == 8'h00) else $error("stored pad not zero");
    key_len_a: assert property (
        (op_r == eksf_pkg::OP_SIG_PASS || op_r == eksf_pkg::OP_PUB_READ)
        && out_valid && out_last |-> cnt_r == 7'h3F)
        else $error("key or signature length");
endmodule

bind eksf_formatter eksf_formatter_props u_eksf_formatter_props (
    .clock(clock), .rst_n(rst_n), .cmd_start(cmd_start), .cmd_op(cmd_op),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .busy(busy), .done(done),
    .key_usable(key_usable), .valid_nibble(valid_nibble));

// [sim/eksf_host_model.sv]
// eksf_host_model: host side of the formatter's byte streams.
// assumes the bench fills tx, calls send, sets slow and reads rx.
`timescale 1ns/100ps
module eksf_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // toward the formatter
    output logic in_valid,
    output logic [7:0] in_data,
    output logic out_ready,
    // from the formatter
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last
);
    logic [7:0] tx [0:99];
    logic [7:0] rx [0:99];
    logic slow = 1'b0;
    logic [1:0] ph = 2'h0;
    int rx_n = 0;
    int last_at = -1;
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        out_ready = 1'b1;
    end
    // ----
    // sink: takes one beat in four when slow
    // ----
    always @(posedge clock) begin
        if (rst_n && out_valid && out_ready) begin
            rx[rx_n] = out_data;
            last_at = out_last ? rx_n : last_at;
            rx_n = rx_n + 1;
        end
        ph = ph + 2'h1;
        #1 out_ready = !slow || ph == 2'h0;
    end
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            in_valid = 1'b1;
            in_data = tx[i];
            @(posedge clock);
            while (in_ready !== 1'b1) @(posedge clock);
            #1;
        end
        in_valid = 1'b0;
        // released lines flip so a stale byte never looks held
        in_data = ~in_data;
    endtask
endmodule

// [sim/eksf_formatter_tb_top.sv]
// eksf_formatter_tb_top: directed scenarios for the key formatter.
// assumes a 10 MHz clock and the host model on both byte streams.
`timescale 1ns/100ps
module eksf_formatter_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_start = 1'b0;
    logic [3:0] cmd_op = 4'h0;
    logic verify_pass = 1'b0;
    logic in_valid, in_ready, out_valid, out_last, out_ready;
    logic busy, done, error, key_usable, cert_two_fit;
    logic [7:0] in_data, out_data;
    logic [3:0] valid_nibble;
    logic seen_done = 1'b0;
    logic err_r = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 clock = ~clock;
    eksf_formatter u_eksf_formatter (.clock(clock), .rst_n(rst_n),
        .cmd_start(cmd_start), .cmd_op(cmd_op), .verify_pass(verify_pass),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .out_ready(out_ready), .busy(busy), .done(done), .error(error),
        .key_usable(key_usable), .valid_nibble(valid_nibble),
        .cert_two_fit(cert_two_fit));
    eksf_host_model u_eksf_host_model (.clock(clock), .rst_n(rst_n),
        .in_valid(in_valid), .in_data(in_data), .out_ready(out_ready),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last));
    // error is valid while done is high; hang guard
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (done === 1'b1) begin
            seen_done = 1'b1;
            err_r = error;
        end
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    // ----
    // shared tasks
    // ----
    task automatic chk(input string what, input logic [15:0] seen, exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] rx(input int i);
        return u_eksf_host_model.rx[i];
    endfunction
    task automatic put(input int i, input logic [7:0] v);
        u_eksf_host_model.tx[i + 2] = v;
    endtask
    task automatic run(input logic [3:0] op, input logic [15:0] p,
                       input int n, input int m, input logic e);
        @(posedge clock);
        #1;
        cmd_start = 1'b1;
        cmd_op = op;
        seen_done = 1'b0;
        u_eksf_host_model.rx_n = 0;
        u_eksf_host_model.last_at = -1;
        @(posedge clock);
        #1;
        cmd_start = 1'b0;
        u_eksf_host_model.tx[0] = p[7:0];
        u_eksf_host_model.tx[1] = p[15:8];
        u_eksf_host_model.send(n + 2);
        for (int i = 0; i < 900 && !seen_done; i++) @(posedge clock);
        for (int i = 0; i < 900 && u_eksf_host_model.rx_n < m; i++)
            @(posedge clock);
        repeat (2) @(posedge clock);
        #1;
        chk("done", 16'(seen_done), 16'h0001);
        chk("error", 16'(err_r), 16'(e));
        chk("out count", 16'(u_eksf_host_model.rx_n), 16'(m));
        chk("last", 16'(u_eksf_host_model.last_at), 16'(m - 1));
    endtask
    task automatic nib(input logic [3:0] n, input logic u);
        chk("nibble", 16'(valid_nibble), 16'(n));
        chk("usable", 16'(key_usable), 16'(u));
    endtask
    // ----
    // scenarios
    // ----
    task automatic s_pub();
        for (int i = 0; i < 64; i++) put(i, 8'(i + 1));
        run(eksf_pkg::OP_PUB_WRITE, 16'h0009, 64, 0, 1'b0);
        nib(4'hA, 1'b0);
        run(eksf_pkg::OP_PUB_READ, 16'h0009, 0, 64, 1'b0);
        for (int i = 0; i < 64; i++) chk("read", rx(i), 8'(i + 1));
        run(eksf_pkg::OP_VERIFY_MSG, 16'h0009, 0, 72, 1'b0);
        for (int i = 1; i < 72; i++)
            chk("stored", rx(i),
                (i % 36 < 4) ? 8'h00 : 8'(i - 3 - i / 36 * 4));
        chk("byte 0", rx(0), 8'hA0);
    endtask
    task automatic s_val();
        run(eksf_pkg::OP_VALIDATE, 16'h0009, 0, 0, 1'b1);
        nib(4'hA, 1'b0);
        verify_pass = 1'b1;
        run(eksf_pkg::OP_VALIDATE, 16'h000A, 0, 0, 1'b1);
        run(eksf_pkg::OP_VALIDATE, 16'h0009, 0, 0, 1'b0);
        nib(4'h5, 1'b1);
        run(eksf_pkg::OP_VERIFY_MSG, 16'h0009, 0, 72, 1'b0);
        chk("byte 0", rx(0), 8'h50);
        run(eksf_pkg::OP_INVALIDATE, 16'h0009, 0, 0, 1'b0);
        nib(4'hA, 1'b0);
        run(eksf_pkg::OP_VALIDATE, 16'h0009, 0, 0, 1'b0);
        run(eksf_pkg::OP_PUB_WRITE, 16'h0008, 64, 0, 1'b0);
        nib(4'hA, 1'b0);
        verify_pass = 1'b0;
        run(eksf_pkg::OP_PUB_READ, 16'h0009, 0, 0, 1'b1);
        run(eksf_pkg::OP_PUB_WRITE, 16'h0007, 0, 0, 1'b1);
        run(eksf_pkg::OP_PUB_WRITE, 16'h0010, 0, 0, 1'b1);
        run(eksf_pkg::OP_PUB_WRITE, 16'h0900, 0, 0, 1'b1);
    endtask
    task automatic s_stream();
        u_eksf_host_model.slow = 1'b1;
        run(eksf_pkg::OP_KEY_GENERATE_CMD_MSG, 16'h0009, 64, 89, 1'b0);
        for (int i = 0; i < 89; i++)
            chk("hash msg", rx(i), i < 25 ? 8'h00 : 8'(i - 24));
        u_eksf_host_model.slow = 1'b0;
        for (int i = 0; i < 64; i++) put(i, 8'hC0 ^ 8'(i));
        run(eksf_pkg::OP_SIG_PASS, 16'h0000, 64, 64, 1'b0);
        for (int i = 0; i < 64; i++) chk("sig", rx(i), 8'hC0 ^ 8'(i));
        for (int i = 0; i < 36; i++) put(i, i < 4 ? 8'h00 : 8'(i));
        run(eksf_pkg::OP_PRIV_WRITE, 16'h0000, 36, 0, 1'b0);
        nib(4'h0, 1'b0);
        run(eksf_pkg::OP_PUB_READ, 16'h0008, 0, 0, 1'b1);
    endtask
    task automatic s_cert();
        logic [15:0] len [0:3];
        len = '{eksf_pkg::DEV_CERT_BYTES, eksf_pkg::SIGNER_CERT_BYTES,
                16'h00D0, 16'h00D1};
        for (int i = 0; i < 4; i++) begin
            run(eksf_pkg::OP_CERT_CHECK, len[i], 0, 0, 1'b0);
            chk("two fit", 16'(cert_two_fit), 16'(i < 3));
        end
        run(eksf_pkg::OP_CERT_CHECK, 16'h01A1, 0, 0, 1'b1);
        run(4'h9, 16'h0009, 0, 0, 1'b1);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk("busy", 16'(busy), 16'h0000);
        nib(4'h0, 1'b0);
        s_pub();
        s_val();
        s_stream();
        s_cert();
        finish_test();
    end
endmodule
